// [hdl/fault_filter.sv]
// Debounced fault level for real-time fault reporting
module fault_filter
    import meas_io_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic fault_raw,
    output logic      fault_stable
);
    typedef struct packed {
        logic        level;
        logic [31:0] cnt;
    } filt_state_t;

    filt_state_t st_reg;
    filt_state_t st_next;

    // ============================================================
    // Settling filter
    always_comb begin
        st_next = st_reg;
        if (fault_raw == st_reg.level) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt + 32'h1 >= FILT_CYC) begin
            st_next.level = fault_raw;
            st_next.cnt   = '0;
        end else begin
            st_next.cnt = st_reg.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign fault_stable = st_reg.level;

    a_filter_bound: assert property (
        @(posedge clk_sys) disable iff (srst) st_reg.cnt < FILT_CYC)
        else $error("filter count overran");
endmodule

// [hdl/meas_io_pkg.sv]
// Constants and types for the measurement handshake port
package meas_io_pkg;
    localparam int CLK_HZ       = 200_000_000;
    localparam int CYC_PER_US   = CLK_HZ / 1_000_000;
    // Times in microseconds
    localparam int T_FAULT_US   = 1500;
    localparam int T_TRIG_MIN_US = 500;
    localparam int T_CALC_US    = 300;
    localparam int T_CALC_STAT_US = 300;
    localparam int T_CALC_REF_US = 150;
    localparam int T_SETTLE_US  = 10_000;
    localparam int T_EOM_XF_US  = 1000;
    localparam int T_EOM_F_US   = 5000;
    localparam int T_EOM_M50_US = 20_000;
    localparam int T_EOM_M60_US = 16_000;
    localparam int T_EOM_S_US   = 50_000;
    // Measuring time: [mode combined][rate][line60]
    localparam int T_MEAS_XF_C_US = 7800;
    localparam int T_MEAS_F_C_US  = 23_800;
    localparam int T_MEAS_M50_C_US = 83_800;
    localparam int T_MEAS_M60_C_US = 69_800;
    localparam int T_MEAS_S50_C_US = 258_800;
    localparam int T_MEAS_S60_C_US = 252_200;
    localparam int T_MEAS_XF_S_US = 3400;
    localparam int T_MEAS_F_S_US  = 11_400;
    localparam int T_MEAS_M50_S_US = 41_400;
    localparam int T_MEAS_M60_S_US = 34_400;
    localparam int T_MEAS_S50_S_US = 156_400;
    localparam int T_MEAS_S60_S_US = 149_800;
    // Averaging overlap k
    localparam int K_FAST_C_US  = 2800;
    localparam int K_FAST_S_US  = 1400;
    localparam int K_S50_C_US   = 57_800;
    localparam int K_S60_C_US   = 51_200;
    localparam int K_S50_S_US   = 56_400;
    localparam int K_S60_S_US   = 49_800;
    localparam logic [31:0] FAULT_CYC = 32'(T_FAULT_US * CYC_PER_US);
    localparam logic [31:0] CALC_CYC  = 32'(T_CALC_US * CYC_PER_US);
    localparam logic [31:0] CALC_STAT_CYC = 32'(T_CALC_STAT_US * CYC_PER_US);
    localparam logic [31:0] CALC_REF_CYC  = 32'(T_CALC_REF_US * CYC_PER_US);
    localparam logic [31:0] MS_CYC    = 32'(1000 * CYC_PER_US);
    localparam logic [31:0] FILT_CYC  = 32'(100 * CYC_PER_US);

    typedef enum logic [1:0] {
        RATE_XFAST = 2'b00,
        RATE_FAST  = 2'b01,
        RATE_MED   = 2'b10,
        RATE_SLOW  = 2'b11
    } rate_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DELAY = 3'b001,
        ST_MEAS  = 3'b010,
        ST_CALC  = 3'b011,
        ST_DONE  = 3'b100
    } phase_t;

    typedef struct packed {
        rate_t       rate;
        logic        line_60hz;
        logic        combined_mode;
        logic        ext_trigger;
        logic        eom_pulse;
        logic [15:0] eom_width_ms;
        logic        fault_realtime_mode;
        logic        stats_en;
        logic        ref_tol_en;
        logic [7:0]  avg_count;
        logic [31:0] delay_cyc;
    } meas_cfg_t;

    typedef struct packed {
        logic end_of_measurement_n;
        logic analog_done_n;
        logic fault_n;
        logic busy;
    } meas_out_t;

    // Cycles of the measuring phase for one setting
    function automatic logic [31:0] meas_cycles(meas_cfg_t c);
        int base;
        int k;
        int n;
        base = 0;
        k = 0;
        n = (c.avg_count == 8'h00) ? 1 : int'(c.avg_count);
        unique case (c.rate)
            RATE_XFAST: base = c.combined_mode ? T_MEAS_XF_C_US : T_MEAS_XF_S_US;
            RATE_FAST:  base = c.combined_mode ? T_MEAS_F_C_US : T_MEAS_F_S_US;
            RATE_MED: begin
                if (c.combined_mode) begin
                    base = c.line_60hz ? T_MEAS_M60_C_US : T_MEAS_M50_C_US;
                end else begin
                    base = c.line_60hz ? T_MEAS_M60_S_US : T_MEAS_M50_S_US;
                end
            end
            RATE_SLOW: begin
                if (c.combined_mode) begin
                    base = c.line_60hz ? T_MEAS_S60_C_US : T_MEAS_S50_C_US;
                end else begin
                    base = c.line_60hz ? T_MEAS_S60_S_US : T_MEAS_S50_S_US;
                end
            end
        endcase
        if (c.rate == RATE_SLOW) begin
            if (c.combined_mode) begin
                k = c.line_60hz ? K_S60_C_US : K_S50_C_US;
            end else begin
                k = c.line_60hz ? K_S60_S_US : K_S50_S_US;
            end
        end else begin
            k = c.combined_mode ? K_FAST_C_US : K_FAST_S_US;
        end
        if (!c.ext_trigger) begin
            n = 1;
        end
        return 32'((base - k) * n * CYC_PER_US + k * CYC_PER_US);
    endfunction

    // Cycles of hold-style end under internal trigger
    function automatic logic [31:0] eom_hold_cycles(meas_cfg_t c);
        int us;
        us = 0;
        unique case (c.rate)
            RATE_XFAST: us = T_EOM_XF_US;
            RATE_FAST:  us = T_EOM_F_US;
            RATE_MED:   us = c.line_60hz ? T_EOM_M60_US : T_EOM_M50_US;
            RATE_SLOW:  us = T_EOM_S_US;
        endcase
        return 32'(us * CYC_PER_US);
    endfunction
endpackage

// [hdl/measurement_handshake_io.sv]
// Measurement cycle sequencer and handshake outputs
module measurement_handshake_io
    import meas_io_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      srst,
    input  wire logic      ce,
    input  wire meas_cfg_t cfg,
    input  wire logic      trigger_n,
    input  wire logic      lead_fault,
    output meas_out_t      outs
);
    typedef struct packed {
        phase_t      phase;
        logic [31:0] cnt;
        logic [31:0] eom_cnt;
        logic        eom_active;
        logic        trig_prev;
        logic        meas_fault;
        logic        sync_fault_n;
        logic        eom_n;
        logic        done_n;
        logic        fault_out_n;
    } core_state_t;

    core_state_t st_reg;
    core_state_t st_next;
    logic        fault_stable;
    logic        trig_fall;
    logic [31:0] calc_cyc;

    fault_filter u_filter (
        .clk_sys      (clk_sys),
        .srst         (srst),
        .ce           (ce),
        .fault_raw    (lead_fault),
        .fault_stable (fault_stable)
    );

    assign calc_cyc = CALC_CYC + (cfg.stats_en ? CALC_STAT_CYC : 32'h0)
                    + (cfg.ref_tol_en ? CALC_REF_CYC : 32'h0);

    // falling edge of trigger, external only
    assign trig_fall = cfg.ext_trigger && st_reg.trig_prev && !trigger_n;

    // ============================================================
    // Sequencer
    always_comb begin
        st_next = st_reg;
        st_next.trig_prev = trigger_n;
        // End output timing
        if (st_reg.eom_active) begin
            if (cfg.ext_trigger && !cfg.eom_pulse) begin
                st_next.eom_n = 1'b0;
            end else if (st_reg.eom_cnt <= 32'h1) begin
                st_next.eom_active = 1'b0;
                st_next.eom_n      = 1'b1;
            end else begin
                st_next.eom_cnt = st_reg.eom_cnt - 32'h1;
            end
        end
        unique case (st_reg.phase)
            ST_IDLE: begin
                if (trig_fall || !cfg.ext_trigger) begin
                    if (trig_fall) begin
                        st_next.eom_active = 1'b0;
                        st_next.eom_n      = 1'b1;
                    end
                    st_next.done_n = 1'b1;
                    if (cfg.delay_cyc == 32'h0) begin
                        st_next.phase = ST_MEAS;
                        st_next.cnt   = meas_cycles(cfg);
                    end else begin
                        st_next.phase = ST_DELAY;
                        st_next.cnt   = cfg.delay_cyc;
                    end
                    st_next.meas_fault = 1'b0;
                end
            end
            ST_DELAY: begin
                if (st_reg.cnt <= 32'h1) begin
                    st_next.phase = ST_MEAS;
                    st_next.cnt   = meas_cycles(cfg);
                end else begin
                    st_next.cnt = st_reg.cnt - 32'h1;
                end
            end
            ST_MEAS: begin
                if (lead_fault) begin
                    st_next.meas_fault = 1'b1;
                end
                if (st_reg.cnt <= 32'h1) begin
                    st_next.phase  = ST_CALC;
                    st_next.cnt    = calc_cyc;
                    st_next.done_n = 1'b0;
                end else begin
                    st_next.cnt = st_reg.cnt - 32'h1;
                end
            end
            ST_CALC: begin
                if (st_reg.cnt <= 32'h1) begin
                    st_next.phase = ST_DONE;
                end else begin
                    st_next.cnt = st_reg.cnt - 32'h1;
                end
            end
            ST_DONE: begin
                st_next.sync_fault_n = !st_reg.meas_fault;
                st_next.eom_n        = 1'b0;
                st_next.eom_active   = 1'b1;
                st_next.eom_cnt = cfg.eom_pulse
                    ? 32'(cfg.eom_width_ms) * MS_CYC
                    : eom_hold_cycles(cfg);
                st_next.phase = ST_IDLE;
            end
            default: st_next.phase = ST_IDLE;
        endcase
        if (cfg.fault_realtime_mode) begin
            st_next.fault_out_n = !fault_stable;
        end else begin
            st_next.fault_out_n = st_next.sync_fault_n;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= '{phase: ST_IDLE, cnt: 32'h0, eom_cnt: 32'h0,
                        eom_active: 1'b0, trig_prev: 1'b1,
                        meas_fault: 1'b0, sync_fault_n: 1'b1,
                        eom_n: 1'b1, done_n: 1'b1, fault_out_n: 1'b1};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign outs.end_of_measurement_n = st_reg.eom_n;
    assign outs.analog_done_n        = st_reg.done_n;
    assign outs.fault_n              = st_reg.fault_out_n;
    assign outs.busy                 = (st_reg.phase != ST_IDLE);

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_reset_high: assert property (
        $past(srst) |-> outs.end_of_measurement_n && outs.analog_done_n)
        else $error("outputs not high after reset");
    a_sync_fault: assert property (
        ce && st_reg.phase == ST_DONE && !cfg.fault_realtime_mode
        |=> outs.fault_n == !$past(st_reg.meas_fault))
        else $error("sync fault wrong");
    a_sync_stable: assert property (
        !cfg.fault_realtime_mode && $stable(cfg)
        && st_reg.phase != ST_DONE |=> $stable(outs.fault_n))
        else $error("sync fault moved off end");
    a_rt_follow: assert property (
        ce && cfg.fault_realtime_mode
        && $stable(cfg.fault_realtime_mode)
        |=> outs.fault_n == !$past(fault_stable))
        else $error("realtime fault wrong");
    a_ignore_int: assert property (
        !cfg.ext_trigger && st_reg.phase == ST_IDLE
        && ce |=> st_reg.phase != ST_IDLE)
        else $error("internal trigger not free running");
    a_edge_start: assert property (
        ce && trig_fall && st_reg.phase == ST_IDLE
        |=> st_reg.phase inside {ST_DELAY, ST_MEAS})
        else $error("edge did not start");
    a_hold_ext: assert property (
        ce && cfg.ext_trigger && !cfg.eom_pulse
        && !outs.end_of_measurement_n && !trig_fall && $stable(cfg)
        |=> !outs.end_of_measurement_n)
        else $error("hold released early");
    a_calc_len: assert property (
        ce && st_reg.phase == ST_MEAS
        && st_reg.cnt <= 32'h1 |=> st_reg.cnt == calc_cyc)
        else $error("calc length wrong");
    a_delay_first: assert property (
        ce && st_reg.phase == ST_DELAY
        && st_reg.cnt <= 32'h1 |=> st_reg.phase == ST_MEAS)
        else $error("delay did not lead to measuring");
    a_pulse_width: assert property (
        ce && st_reg.phase == ST_DONE && cfg.eom_pulse
        |=> st_reg.eom_cnt == 32'(cfg.eom_width_ms) * MS_CYC)
        else $error("pulse width wrong");
    a_int_hold: assert property (
        ce && st_reg.phase == ST_DONE
        && !cfg.eom_pulse && !cfg.ext_trigger
        |=> st_reg.eom_cnt == eom_hold_cycles(cfg))
        else $error("internal hold width wrong");
    a_meas_len: assert property (
        ce && st_reg.phase == ST_DELAY
        && st_reg.cnt <= 32'h1 |=> st_reg.cnt == meas_cycles(cfg))
        else $error("measuring length wrong");

    c_ext_cycle: cover property (trig_fall ##1 st_reg.phase == ST_DELAY);
    c_done: cover property (st_reg.phase == ST_DONE);
    c_fault: cover property (st_reg.phase == ST_DONE && st_reg.meas_fault);
    c_pulse: cover property (cfg.eom_pulse && st_reg.eom_active);
endmodule

// [verification/testbench.sv]
// Self-checking bench for the measurement handshake port
module testbench
    import meas_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    // ==========================================================
    localparam int MEAS_CYC = T_MEAS_XF_S_US * CYC_PER_US;
    localparam int DLY      = 100;
    localparam int M_LO     = DLY + MEAS_CYC - 4;
    localparam int M_HI     = DLY + MEAS_CYC + 4;
    localparam int LIMIT    = 2_000_000;
    localparam int CALC     = int'(CALC_CYC + CALC_STAT_CYC + CALC_REF_CYC);
    localparam int W_CYC    = int'(MS_CYC);
    localparam int F_CYC    = int'(FAULT_CYC);

    logic      clk_sys;
    logic      srst;
    logic      ce;
    logic      lead_fault;
    logic      fire;
    logic      trigger_n;
    meas_cfg_t cfg;
    meas_out_t outs;
    int        n_errors = 0;
    int        n_tests  = 0;
    int        cycles   = 0;
    int        n;

    measurement_handshake_io dut (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .ce         (ce),
        .cfg        (cfg),
        .trigger_n  (trigger_n),
        .lead_fault (lead_fault),
        .outs       (outs)
    );

    trig_ctrl_model ctrl (
        .clk_sys   (clk_sys),
        .fire      (fire),
        .trigger_n (trigger_n)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic end_of_test();
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_bit(string name, logic exp, logic seen);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b, seen %b", name, exp, seen);
        end
    endtask

    task automatic check_range(string name, int lo, int hi, int seen);
        n_tests++;
        if (seen < lo || seen > hi) begin
            n_errors++;
            $display("unexpected %s: expected %0d..%0d, seen %0d",
                     name, lo, hi, seen);
        end
    endtask

    function automatic logic sig(int idx);
        case (idx)
            0: return outs.end_of_measurement_n;
            1: return outs.analog_done_n;
            2: return outs.fault_n;
            default: return outs.busy;
        endcase
    endfunction

    task automatic wait_sig(int idx, logic lvl, int limit, output int cnt);
        cnt = 0;
        while (sig(idx) !== lvl && cnt < limit) begin
            @(negedge clk_sys);
            cnt++;
        end
    endtask

    task automatic start_meas();
        @(negedge clk_sys);
        fire <= 1'b1;
        @(negedge clk_sys);
        fire <= 1'b0;
        @(negedge clk_sys);
        @(negedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            end_of_test();
        end
    end

    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        lead_fault = 1'b0;
        fire = 1'b0;
        cfg = '0;
        cfg.rate = RATE_XFAST;
        cfg.ext_trigger = 1'b1;
        cfg.avg_count = 8'h01;
        cfg.delay_cyc = 32'(DLY);
        cfg.stats_en = 1'b1;
        cfg.ref_tol_en = 1'b1;
        repeat (16) @(negedge clk_sys);
        srst <= 1'b0;
        repeat (200) @(negedge clk_sys);
        check_bit("eom_n", 1'b1, outs.end_of_measurement_n);
        check_bit("done_n", 1'b1, outs.analog_done_n);
        check_bit("busy", 1'b0, outs.busy);
        // Hold style, fault inside the measuring phase
        start_meas();
        check_bit("busy", 1'b1, outs.busy);
        fork
            wait_sig(1, 1'b0, DLY + MEAS_CYC + 10, n);
            begin
                repeat (DLY + 1000) @(negedge clk_sys);
                lead_fault <= 1'b1;
            end
        join
        check_range("meas_time", M_LO, M_HI, n);
        check_bit("fault_n", 1'b1, outs.fault_n);
        wait_sig(0, 1'b0, CALC + 10, n);
        check_range("calc_time", CALC, CALC + 4, n);
        check_bit("fault_n", 1'b0, outs.fault_n);
        lead_fault <= 1'b0;
        repeat (2000) @(negedge clk_sys);
        check_bit("eom_n", 1'b0, outs.end_of_measurement_n);
        check_bit("fault_n", 1'b0, outs.fault_n);
        // Pulse style, fault only in delay, retrigger while busy
        cfg.eom_pulse <= 1'b1;
        cfg.eom_width_ms <= 16'h0001;
        lead_fault <= 1'b1;
        start_meas();
        check_bit("eom_n", 1'b1, outs.end_of_measurement_n);
        check_bit("done_n", 1'b1, outs.analog_done_n);
        fork
            wait_sig(1, 1'b0, DLY + MEAS_CYC + 10, n);
            begin
                repeat (DLY / 2) @(negedge clk_sys);
                lead_fault <= 1'b0;
                repeat (150_000) @(negedge clk_sys);
                fire <= 1'b1;
                @(negedge clk_sys);
                fire <= 1'b0;
            end
        join
        check_range("meas_time", M_LO, M_HI, n);
        wait_sig(0, 1'b0, CALC + 10, n);
        check_bit("fault_n", 1'b1, outs.fault_n);
        wait_sig(0, 1'b1, W_CYC + 10, n);
        check_range("eom_width", W_CYC - 2, W_CYC + 2, n);
        // Real-time fault following the lead state
        cfg.fault_realtime_mode <= 1'b1;
        lead_fault <= 1'b1;
        @(negedge clk_sys);
        wait_sig(2, 1'b0, F_CYC + 1, n);
        check_range("fault_set", 0, F_CYC, n);
        lead_fault <= 1'b0;
        @(negedge clk_sys);
        wait_sig(2, 1'b1, F_CYC + 1, n);
        check_range("fault_clear", 0, F_CYC, n);
        // Internal trigger starts without a request
        cfg.ext_trigger <= 1'b0;
        @(negedge clk_sys);
        @(negedge clk_sys);
        check_bit("busy_int", 1'b1, outs.busy);
        end_of_test();
    end
endmodule

// [verification/trig_ctrl_model.sv]
// Controller model that drives the measurement request line
module trig_ctrl_model
    import meas_io_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic fire,
    output logic      trigger_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Request pulse
    // ==========================================================
    localparam int HOLD_CYC = T_TRIG_MIN_US * CYC_PER_US + 20;

    int cnt = 0;

    initial begin
        trigger_n = 1'b1;
    end

    always @(negedge clk_sys) begin
        if (fire && cnt == 0) begin
            trigger_n <= 1'b0;
            cnt <= HOLD_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                trigger_n <= 1'b1;
            end
        end
    end
endmodule
